// ==== verilog/wsup_pkg.sv ====
/*
  package for the window supervisor: register offsets, field positions,
  reset values, timing counts and bus carrier structs.
  assumes a single 32-bit avalon-mm slave port on the peripheral bus clock.
*/
`default_nettype none

package wsup_pkg;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [3:0] CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] CONFIG_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFFSET = 4'hC;

  // ***********************************************************
  // fields and reset values
  // ***********************************************************
  localparam int ACTIVATE_BIT_POS = 7;
  localparam int TIMEBASE_LSB = 7;
  localparam int EW_IRQ_ENABLE_POS = 9;
  localparam int EW_FLAG_POS = 0;
  localparam logic [6:0] COUNTER_RESET = 7'h7F;
  localparam logic [6:0] WINDOW_RESET = 7'h7F;
  localparam logic [6:0] WARN_VALUE = 7'h40;
  localparam logic [1:0] TIMEBASE_RESET = 2'h0;
  localparam logic STATUS_RESET = 1'b0;
  localparam logic MASK_RESET = 1'b0;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int BASE_DIVIDE = 4096;
  localparam int PRESCALE_WIDTH = 15;

  // ***********************************************************
  // bus carriers
  // ***********************************************************
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } wsup_bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } wsup_bus_rsp_t;

endpackage

`default_nettype wire

// ==== verilog/wsup_top.sv ====
/*
  window supervisor: 7-bit down-counter watchdog with window check,
  early warning flag and interrupt, avalon-mm register slave.
  assumes one clock (peripheral bus clock) and an asynchronous active-low reset;
  bus inputs are synchronous to clock_i.
*/
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - activate bit set by software, cleared by reset
// - counter decrements every 4096 times 2^timebase
// - active: reset request on 0x40 to 0x3F
// - irq enable with irq mask set raises interrupt at 0x40
// - irq enable sticks until reset
// - timebase selects divide by 1,2,4,8
// - window bounds the counter at refresh
// - early warning flag set at 0x40
// - flag cleared by writing 0, 1 ignored
// - flag set even with irq disabled
// - control and config reset to 0x7F
// - active: refresh above window causes reset
// - counter runs even when not activated
// - debug freeze stops the counter
module wsup_top #(
  parameter int BASE_DIVIDE = wsup_pkg::BASE_DIVIDE
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // avalon-mm slave
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // debug
  input wire logic core_halted_i,
  input wire logic debug_freeze_control_i,
  // system
  output logic system_reset_req_o,
  output logic irq_o
);

  // ***********************************************************
  // state
  // ***********************************************************
  typedef enum {WSUP_IDLE, WSUP_DONE} wsup_bus_state_t;

  wsup_bus_state_t bus_state, next_bus_state;
  logic [6:0] counter, next_counter;
  logic activate_bit, next_activate_bit;
  logic [6:0] window, next_window;
  logic [1:0] timebase_select, next_timebase_select;
  logic early_warning_irq_enable, next_early_warning_irq_enable;
  logic early_warning_flag, next_early_warning_flag;
  logic irq_mask, next_irq_mask;
  logic [wsup_pkg::PRESCALE_WIDTH-1:0] prescale, next_prescale;
  logic system_reset_req, next_system_reset_req;
  logic irq, next_irq;
  logic [31:0] readdata, next_readdata;
  logic waitrequest, next_waitrequest;

  wsup_pkg::wsup_bus_req_t req;
  logic tick;
  logic frozen;
  logic access;
  logic wr_control;
  logic wr_config;
  logic wr_status;
  logic wr_mask;

  assign req = '{address: address_i, read: read_i, write: write_i, writedata: writedata_i};

  function automatic logic is_write_to(input wsup_pkg::wsup_bus_req_t r, input logic [3:0] off);
    is_write_to = r.write && (r.address == off);
  endfunction

  // one decrement period expressed as a prescaler terminal count
  function automatic logic [wsup_pkg::PRESCALE_WIDTH-1:0] period_last(input logic [1:0] tb);
    logic [31:0] full;
    full = (BASE_DIVIDE << tb) - 1;
    period_last = full[wsup_pkg::PRESCALE_WIDTH-1:0];
  endfunction

  // ***********************************************************
  // bus slave: one wait cycle, accepted on the second edge
  // ***********************************************************
  assign access = (req.read || req.write) && (bus_state == WSUP_IDLE);
  assign wr_control = access && is_write_to(req, wsup_pkg::CONTROL_OFFSET);
  assign wr_config = access && is_write_to(req, wsup_pkg::CONFIG_OFFSET);
  assign wr_status = access && is_write_to(req, wsup_pkg::STATUS_OFFSET);
  assign wr_mask = access && is_write_to(req, wsup_pkg::IRQ_MASK_OFFSET);

  always_comb begin
    next_bus_state = WSUP_IDLE;
    next_waitrequest = 1'b1;
    next_readdata = readdata;
    case (bus_state)
      WSUP_IDLE: begin
        if (req.read || req.write) begin
          next_bus_state = WSUP_DONE;
          next_waitrequest = 1'b0;
          next_readdata = 32'h0000_0000;
          if (req.read) begin
            case (req.address)
              wsup_pkg::CONTROL_OFFSET: next_readdata = {24'h000000, activate_bit, counter};
              wsup_pkg::CONFIG_OFFSET:
                next_readdata = {22'h000000, early_warning_irq_enable, timebase_select, window};
              wsup_pkg::STATUS_OFFSET: next_readdata = {31'h00000000, early_warning_flag};
              wsup_pkg::IRQ_MASK_OFFSET: next_readdata = {31'h00000000, irq_mask};
              default: next_readdata = 32'h0000_0000;
            endcase
          end
        end
      end
      WSUP_DONE: begin
        next_bus_state = WSUP_IDLE;
        next_waitrequest = 1'b1;
      end
      default: next_bus_state = WSUP_IDLE;
    endcase
  end

  // ***********************************************************
  // configuration registers
  // ***********************************************************
  always_comb begin
    next_activate_bit = activate_bit;
    next_window = window;
    next_timebase_select = timebase_select;
    next_early_warning_irq_enable = early_warning_irq_enable;
    next_irq_mask = irq_mask;
    if (wr_control && req.writedata[wsup_pkg::ACTIVATE_BIT_POS]) begin
      next_activate_bit = 1'b1;
    end
    if (wr_config) begin
      next_window = req.writedata[6:0];
      next_timebase_select = req.writedata[wsup_pkg::TIMEBASE_LSB +: 2];
      if (req.writedata[wsup_pkg::EW_IRQ_ENABLE_POS]) begin
        next_early_warning_irq_enable = 1'b1;
      end
    end
    if (wr_mask) begin
      next_irq_mask = req.writedata[wsup_pkg::EW_FLAG_POS];
    end
  end

  // ***********************************************************
  // prescaler, counter, reset and warning
  // ***********************************************************
  assign frozen = core_halted_i && debug_freeze_control_i;
  assign tick = !frozen && (prescale >= period_last(timebase_select));

  always_comb begin
    next_prescale = prescale;
    next_counter = counter;
    next_system_reset_req = 1'b0;
    next_early_warning_flag = early_warning_flag;
    if (!frozen) begin
      next_prescale = tick ? '0 : prescale + 1'b1;
    end
    // counter runs whether or not activated
    if (wr_control) begin
      next_counter = req.writedata[6:0];
      next_prescale = '0;
      if (activate_bit && (counter > window)) begin
        next_system_reset_req = 1'b1;
      end
    end else if (tick) begin
      next_counter = counter - 7'h01;
      if (activate_bit && (counter == wsup_pkg::WARN_VALUE)) begin
        next_system_reset_req = 1'b1;
      end
    end
    if (wr_status && !req.writedata[wsup_pkg::EW_FLAG_POS]) begin
      next_early_warning_flag = 1'b0;
    end
    if (!wr_control && tick && (counter == wsup_pkg::WARN_VALUE + 7'h01)) begin
      next_early_warning_flag = 1'b1;
    end
    next_irq = next_early_warning_flag && next_early_warning_irq_enable && next_irq_mask;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_state <= WSUP_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
      counter <= wsup_pkg::COUNTER_RESET;
      activate_bit <= 1'b0;
      window <= wsup_pkg::WINDOW_RESET;
      timebase_select <= wsup_pkg::TIMEBASE_RESET;
      early_warning_irq_enable <= 1'b0;
      early_warning_flag <= wsup_pkg::STATUS_RESET;
      irq_mask <= wsup_pkg::MASK_RESET;
      prescale <= '0;
      system_reset_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
      counter <= next_counter;
      activate_bit <= next_activate_bit;
      window <= next_window;
      timebase_select <= next_timebase_select;
      early_warning_irq_enable <= next_early_warning_irq_enable;
      early_warning_flag <= next_early_warning_flag;
      irq_mask <= next_irq_mask;
      prescale <= next_prescale;
      system_reset_req <= next_system_reset_req;
      irq <= next_irq;
    end
  end

  assign readdata_o = readdata;
  assign waitrequest_o = waitrequest;
  assign system_reset_req_o = system_reset_req;
  assign irq_o = irq;

  // ***********************************************************
  // assertions
  // ***********************************************************
  sequence s_roll_past_warn;
    activate_bit && tick && !wr_control && (counter == wsup_pkg::WARN_VALUE);
  endsequence

  property p_activate_sticky;
    @(posedge clock_i) disable iff (!reset_n_i) activate_bit |=> activate_bit;
  endproperty
  a_activate_sticky: assert property (p_activate_sticky) else $error("activate bit cleared");

  property p_roll_reset;
    @(posedge clock_i) disable iff (!reset_n_i) s_roll_past_warn |=> system_reset_req_o && counter == 7'h3F;
  endproperty
  a_roll_reset: assert property (p_roll_reset) else $error("no reset at rollover");

  property p_reset_pulse;
    @(posedge clock_i) disable iff (!reset_n_i) system_reset_req_o |=> !system_reset_req_o;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset request wider than one cycle");

  property p_irq_enable_sticky;
    @(posedge clock_i) disable iff (!reset_n_i) early_warning_irq_enable |=> early_warning_irq_enable;
  endproperty
  a_irq_enable_sticky: assert property (p_irq_enable_sticky) else $error("irq enable cleared");

  property p_flag_at_warn;
    @(posedge clock_i) disable iff (!reset_n_i)
      (tick && !wr_control && counter == 7'h41) |=> early_warning_flag && counter == 7'h40;
  endproperty
  a_flag_at_warn: assert property (p_flag_at_warn) else $error("flag not set at warning");

  property p_write_one_keeps;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_status && req.writedata[0] && early_warning_flag) |=> early_warning_flag;
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) else $error("write of one cleared flag");

  property p_window_refresh;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_control && activate_bit && counter > window) |=> system_reset_req_o;
  endproperty
  a_window_refresh: assert property (p_window_refresh) else $error("early refresh not caught");

  property p_refresh_loads;
    @(posedge clock_i) disable iff (!reset_n_i) wr_control |=> counter == $past(req.writedata[6:0]);
  endproperty
  a_refresh_loads: assert property (p_refresh_loads) else $error("refresh did not load counter");

  property p_freeze;
    @(posedge clock_i) disable iff (!reset_n_i)
      (frozen && !wr_control) |=> $stable(counter) && $stable(prescale);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while frozen");

  property p_irq_level;
    @(posedge clock_i) disable iff (!reset_n_i)
      irq_o == (early_warning_flag && early_warning_irq_enable && irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt missing");

  property p_flag_clear;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_status && !req.writedata[wsup_pkg::EW_FLAG_POS] && !(tick && counter == 7'h41)) |=> !early_warning_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write of zero left flag set");

  property p_inactive_quiet;
    @(posedge clock_i) disable iff (!reset_n_i) !activate_bit |=> !system_reset_req_o;
  endproperty
  a_inactive_quiet: assert property (p_inactive_quiet) else $error("reset request while inactive");

  property p_counter_runs;
    @(posedge clock_i) disable iff (!reset_n_i) (tick && !wr_control) |=> counter == $past(counter) - 7'h01;
  endproperty
  a_counter_runs: assert property (p_counter_runs) else $error("counter missed a decrement");

  property p_prescale_restart;
    @(posedge clock_i) disable iff (!reset_n_i) wr_control |=> prescale == '0;
  endproperty
  a_prescale_restart: assert property (p_prescale_restart) else $error("prescaler kept running at refresh");

endmodule

`default_nettype wire

// ==== testbench/tb_window_watchdog.sv ====
/*
  self-checking testbench for the window supervisor: register reset values,
  counter timing per timebase, early warning flag and interrupt, window refresh
  and rollover reset pulses, debug freeze.
  assumes wsup_top with a shortened base divide, one 200 MHz clock and the
  one-wait-cycle avalon-mm slave described for it.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_window_watchdog;
  localparam int BASE = 8;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] address_i = 4'h0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic core_halted_i = 1'b0;
  logic debug_freeze_control_i = 1'b0;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic system_reset_req_o;
  logic irq_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int pulse_cnt = 0;
  int p;
  logic [31:0] rd_val;

  wsup_top #(.BASE_DIVIDE(BASE)) u_dut (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .address_i(address_i),
    .read_i(read_i),
    .write_i(write_i),
    .writedata_i(writedata_i),
    .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o),
    .core_halted_i(core_halted_i),
    .debug_freeze_control_i(debug_freeze_control_i),
    .system_reset_req_o(system_reset_req_o),
    .irq_o(irq_o)
  );

  always #2.5 clock_i = ~clock_i;

  // counts cycles the reset request is high, so a stretched pulse shows up
  always @(posedge clock_i) begin
    if (system_reset_req_o === 1'b1) pulse_cnt <= pulse_cnt + 1;
  end

  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_access(input logic is_write, input logic [3:0] a, input logic [31:0] d);
    address_i <= a;
    writedata_i <= d;
    write_i <= is_write;
    read_i <= !is_write;
    // hold the request until waitrequest is sampled low; the watchdog ends a hang
    do begin
      @(posedge clock_i);
    end while (waitrequest_o !== 1'b0);
    rd_val = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus_access(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a);
    bus_access(1'b0, a, 32'h0);
  endtask

  task automatic complete_run();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge clock_i);
    error_cnt++;
    complete_run();
  end

  // ***********************************************************
  // tests
  // ***********************************************************
  initial begin
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    rd(wsup_pkg::CONTROL_OFFSET);
    check(rd_val, 32'h7F);
    rd(wsup_pkg::CONFIG_OFFSET);
    check(rd_val, 32'h7F);
    rd(wsup_pkg::STATUS_OFFSET);
    check(rd_val, 32'h0);
    rd(wsup_pkg::IRQ_MASK_OFFSET);
    check(rd_val, 32'h0);
    rd(4'h2);
    check(rd_val, 32'h0);
    // read lands mid-way between the third and fourth decrement
    for (int tb = 0; tb < 4; tb++) begin
      p = BASE << tb;
      wr(wsup_pkg::CONFIG_OFFSET, {23'h0, tb[1:0], 7'h7F});
      wr(wsup_pkg::CONTROL_OFFSET, 32'h50);
      repeat (3 * p + p / 2 - 3) @(posedge clock_i);
      rd(wsup_pkg::CONTROL_OFFSET);
      check(rd_val, 32'h4D);
    end
    wr(wsup_pkg::CONFIG_OFFSET, 32'h7F);
    wr(wsup_pkg::CONTROL_OFFSET, 32'h42);
    repeat (30) @(posedge clock_i);
    rd(wsup_pkg::STATUS_OFFSET);
    check(rd_val, 32'h1);
    check({31'h0, irq_o}, 32'h0);
    wr(wsup_pkg::STATUS_OFFSET, 32'h1);
    rd(wsup_pkg::STATUS_OFFSET);
    check(rd_val, 32'h1);
    wr(wsup_pkg::IRQ_MASK_OFFSET, 32'h1);
    check({31'h0, irq_o}, 32'h0);
    wr(wsup_pkg::CONFIG_OFFSET, 32'h27F);
    check({31'h0, irq_o}, 32'h1);
    wr(wsup_pkg::IRQ_MASK_OFFSET, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    wr(wsup_pkg::IRQ_MASK_OFFSET, 32'h1);
    wr(wsup_pkg::STATUS_OFFSET, 32'h0);
    rd(wsup_pkg::STATUS_OFFSET);
    check(rd_val, 32'h0);
    check({31'h0, irq_o}, 32'h0);
    wr(wsup_pkg::CONFIG_OFFSET, 32'h0);
    rd(wsup_pkg::CONFIG_OFFSET);
    check(rd_val, 32'h200);
    check(32'(pulse_cnt), 32'h0);
    // activate just above the warning value and let it roll over
    wr(wsup_pkg::CONFIG_OFFSET, 32'h27F);
    wr(wsup_pkg::CONTROL_OFFSET, 32'hC1);
    repeat (20) @(posedge clock_i);
    check(32'(pulse_cnt), 32'h1);
    wr(wsup_pkg::CONTROL_OFFSET, 32'h7F);
    rd(wsup_pkg::CONTROL_OFFSET);
    check(rd_val & 32'h80, 32'h80);
    check(32'(pulse_cnt), 32'h1);
    // refresh above the window, then inside it
    wr(wsup_pkg::CONFIG_OFFSET, 32'h50);
    wr(wsup_pkg::CONTROL_OFFSET, 32'hFF);
    repeat (2) @(posedge clock_i);
    check(32'(pulse_cnt), 32'h2);
    repeat (440) @(posedge clock_i);
    wr(wsup_pkg::CONTROL_OFFSET, 32'hFF);
    repeat (2) @(posedge clock_i);
    check(32'(pulse_cnt), 32'h2);
    core_halted_i <= 1'b1;
    debug_freeze_control_i <= 1'b1;
    @(posedge clock_i);
    rd(wsup_pkg::CONTROL_OFFSET);
    check(rd_val, 32'hFF);
    repeat (100) @(posedge clock_i);
    rd(wsup_pkg::CONTROL_OFFSET);
    check(rd_val, 32'hFF);
    // still halted but freeze off: prescaler resumes from 4, decrements at +4, +12, +20
    debug_freeze_control_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    rd(wsup_pkg::CONTROL_OFFSET);
    check(rd_val, 32'hFC);
    // a second reset clears the set-only bits
    reset_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    rd(wsup_pkg::CONTROL_OFFSET);
    check(rd_val, 32'h7F);
    rd(wsup_pkg::CONFIG_OFFSET);
    check(rd_val, 32'h7F);
    check({31'h0, irq_o}, 32'h0);
    check(32'(pulse_cnt), 32'h2);
    complete_run();
  end
endmodule

`default_nettype wire
